/* File: bst_pkg.sv */
// Constants, state encoding and instruction codes of the boundary-scan test port
package bst_pkg;
	localparam int BST_NUM_IOB = 4;
	localparam int BST_NUM_IN_ONLY = 1;
	localparam int BST_NUM_OUT_ONLY = 1;
	localparam int BST_CELLS_PER_IOB = 3;
	localparam int BST_IOB_BASE = 2;
	localparam int BST_IN_ONLY_BASE = BST_IOB_BASE + BST_CELLS_PER_IOB * BST_NUM_IOB;
	localparam int BST_OUT_ONLY_BASE = BST_IN_ONLY_BASE + BST_NUM_IN_ONLY;
	localparam int BST_UPD_BIT = BST_OUT_ONLY_BASE + BST_NUM_OUT_ONLY;
	localparam int BST_BSR_LEN = BST_UPD_BIT + 1;
	localparam int BST_CELL_IN = 0;
	localparam int BST_CELL_OUT = 1;
	localparam int BST_CELL_OE = 2;
	localparam int BST_TDO_OE_BIT = 0;
	localparam int BST_TDO_DATA_BIT = 1;
	localparam int BST_IR_LEN = 3;
	localparam int BST_CFG_WIDTH = 8;
	localparam int BST_FIFO_DEPTH = 8;
	localparam logic [2:0] BST_IR_CAPTURE = 3'h1;
	localparam logic [2:0] BST_IR_EXTEST = 3'h0;
	localparam logic [2:0] BST_IR_SAMPLE = 3'h1;
	localparam logic [2:0] BST_IR_USER1 = 3'h2;
	localparam logic [2:0] BST_IR_USER2 = 3'h3;
	localparam logic [2:0] BST_IR_READBACK = 3'h4;
	localparam logic [2:0] BST_IR_CONFIGURE = 3'h5;
	localparam logic [2:0] BST_IR_RESERVED = 3'h6;
	localparam logic [2:0] BST_IR_BYPASS = 3'h7;
	localparam logic [2:0] BST_IR_RESET = BST_IR_BYPASS;
	typedef enum logic [3:0] {
		BST_RESET = 4'h0,
		BST_IDLE = 4'h1,
		BST_SEL_DR = 4'h2,
		BST_CAP_DR = 4'h3,
		BST_SHIFT_DR = 4'h4,
		BST_EXIT1_DR = 4'h5,
		BST_PAUSE_DR = 4'h6,
		BST_EXIT2_DR = 4'h7,
		BST_UPD_DR = 4'h8,
		BST_SEL_IR = 4'h9,
		BST_CAP_IR = 4'ha,
		BST_SHIFT_IR = 4'hb,
		BST_EXIT1_IR = 4'hc,
		BST_PAUSE_IR = 4'hd,
		BST_EXIT2_IR = 4'he,
		BST_UPD_IR = 4'hf
	} bst_state_e;
endpackage

/* File: bst_test_port.sv */
// Boundary-scan test port: controller, registers, user hooks and config word FIFO
`timescale 1ns/100ps

module bst_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign inReady = (count != DEPTH[AW:0]);
	assign outValid = (count != '0);
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outData = mem[rdPtr];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

module bst_test_port (
	// System clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Serial test interface
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdoOut,
	output logic tdoOe,
	// Configuration option strap
	input wire logic scanOption,
	// I/O block pads and core side
	input wire logic [bst_pkg::BST_NUM_IOB-1:0] iobPadIn,
	output logic [bst_pkg::BST_NUM_IOB-1:0] iobPadOut,
	output logic [bst_pkg::BST_NUM_IOB-1:0] iobPadOe,
	output logic [bst_pkg::BST_NUM_IOB-1:0] iobCoreIn,
	input wire logic [bst_pkg::BST_NUM_IOB-1:0] iobCoreOut,
	input wire logic [bst_pkg::BST_NUM_IOB-1:0] iobCoreOe,
	// Input-only and output-only pins
	input wire logic inOnlyPad,
	output logic inOnlyCore,
	output logic outOnlyPad,
	input wire logic outOnlyCore,
	// User logic hooks
	output logic user_instr_one_select,
	output logic user_instr_two_select,
	input wire logic user_scan_out_one,
	input wire logic user_scan_out_two,
	output logic data_reg_shift_clock,
	output logic run_idle_clock_nand,
	output logic update_test_bit,
	// Configuration logic, test clock side
	input wire logic configChainOut,
	input wire logic readbackData,
	output logic configDisable,
	// Configuration words, system clock side
	output logic cfgValid,
	input wire logic cfgReady,
	output logic [bst_pkg::BST_CFG_WIDTH-1:0] cfgData
);
	import bst_pkg::*;

	bst_state_e tapState;
	bst_state_e next_tapState;
	logic [1:0] resetSync;
	logic [1:0] optionSync;
	logic [BST_NUM_IOB-1:0] padSync1;
	logic [BST_NUM_IOB-1:0] padSync2;
	logic [1:0] inOnlySync;
	logic [BST_IR_LEN-1:0] irShift;
	logic [BST_IR_LEN-1:0] instr;
	logic [BST_BSR_LEN-1:0] bsrShift;
	logic [BST_BSR_LEN-1:0] bsrHold;
	logic [BST_BSR_LEN-1:0] bsrCapture;
	logic bypassBit;
	logic tdoSel;
	logic drClockEn;
	logic [BST_CFG_WIDTH-1:0] cfgShift;
	logic [BST_CFG_WIDTH-1:0] cfgWord;
	logic [$clog2(BST_CFG_WIDTH)-1:0] cfgBitCnt;
	logic reqToggle;
	logic [1:0] ackSync;
	logic [2:0] reqSync;
	logic ackToggle;
	logic pending;
	logic fifoReady;
	logic tapReset;
	logic isExtest;
	logic isConfig;

	assign tapReset = resetSync[1] || !optionSync[1];
	assign isExtest = (instr == BST_IR_EXTEST);
	assign isConfig = (instr == BST_IR_CONFIGURE);

	// Power-on reset carried into the test clock domain; no separate test reset pin
	always_ff @(posedge tck) begin
		resetSync <= {resetSync[0], reset};
		optionSync <= {optionSync[0], scanOption};
		padSync1 <= iobPadIn;
		padSync2 <= padSync1;
		inOnlySync <= {inOnlySync[0], inOnlyPad};
	end

	always_comb begin
		next_tapState = tapState;
		case (tapState)
			BST_RESET: next_tapState = tms ? BST_RESET : BST_IDLE;
			BST_IDLE: next_tapState = tms ? BST_SEL_DR : BST_IDLE;
			BST_SEL_DR: next_tapState = tms ? BST_SEL_IR : BST_CAP_DR;
			BST_CAP_DR: next_tapState = tms ? BST_EXIT1_DR : BST_SHIFT_DR;
			BST_SHIFT_DR: next_tapState = tms ? BST_EXIT1_DR : BST_SHIFT_DR;
			BST_EXIT1_DR: next_tapState = tms ? BST_UPD_DR : BST_PAUSE_DR;
			BST_PAUSE_DR: next_tapState = tms ? BST_EXIT2_DR : BST_PAUSE_DR;
			BST_EXIT2_DR: next_tapState = tms ? BST_UPD_DR : BST_SHIFT_DR;
			BST_UPD_DR: next_tapState = tms ? BST_SEL_DR : BST_IDLE;
			BST_SEL_IR: next_tapState = tms ? BST_RESET : BST_CAP_IR;
			BST_CAP_IR: next_tapState = tms ? BST_EXIT1_IR : BST_SHIFT_IR;
			BST_SHIFT_IR: next_tapState = tms ? BST_EXIT1_IR : BST_SHIFT_IR;
			BST_EXIT1_IR: next_tapState = tms ? BST_UPD_IR : BST_PAUSE_IR;
			BST_PAUSE_IR: next_tapState = tms ? BST_EXIT2_IR : BST_PAUSE_IR;
			BST_EXIT2_IR: next_tapState = tms ? BST_UPD_IR : BST_SHIFT_IR;
			BST_UPD_IR: next_tapState = tms ? BST_SEL_DR : BST_IDLE;
			default: next_tapState = BST_RESET;
		endcase
	end

	// Five cycles of TMS high reach the reset state from anywhere
	always_ff @(posedge tck) begin
		if (tapReset) begin
			tapState <= BST_RESET;
		end else begin
			tapState <= next_tapState;
		end
	end

	// Instruction register
	always_ff @(posedge tck) begin
		if (tapReset || tapState == BST_RESET) begin
			irShift <= BST_IR_RESET;
			instr <= BST_IR_RESET;
		end else begin
			case (tapState)
				BST_CAP_IR: irShift <= BST_IR_CAPTURE;
				BST_SHIFT_IR: irShift <= {tdi, irShift[BST_IR_LEN-1:1]};
				BST_UPD_IR: instr <= irShift;
				default: irShift <= irShift;
			endcase
		end
	end

	// Capture values: pins for inputs, core for pad outputs and enables, held values for the TDO and update cells
	always_comb begin
		bsrCapture = '0;
		bsrCapture[BST_TDO_OE_BIT] = bsrHold[BST_TDO_OE_BIT];
		bsrCapture[BST_TDO_DATA_BIT] = bsrHold[BST_TDO_DATA_BIT];
		bsrCapture[BST_UPD_BIT] = bsrHold[BST_UPD_BIT];
		for (int i = 0; i < BST_NUM_IOB; i++) begin
			bsrCapture[BST_IOB_BASE + BST_CELLS_PER_IOB * i + BST_CELL_IN] = padSync2[i];
			bsrCapture[BST_IOB_BASE + BST_CELLS_PER_IOB * i + BST_CELL_OUT] = iobCoreOut[i];
			bsrCapture[BST_IOB_BASE + BST_CELLS_PER_IOB * i + BST_CELL_OE] = iobCoreOe[i];
		end
		bsrCapture[BST_IN_ONLY_BASE] = inOnlySync[1];
		bsrCapture[BST_OUT_ONLY_BASE] = outOnlyCore;
	end

	// Boundary register shifts toward bit 0, which leaves on TDO first
	always_ff @(posedge tck) begin
		if (tapReset) begin
			bsrShift <= '0;
			bsrHold <= '0;
		end else if (instr == BST_IR_EXTEST || instr == BST_IR_SAMPLE) begin
			case (tapState)
				BST_CAP_DR: bsrShift <= bsrCapture;
				BST_SHIFT_DR: bsrShift <= {tdi, bsrShift[BST_BSR_LEN-1:1]};
				BST_UPD_DR: bsrHold <= bsrShift;
				default: bsrShift <= bsrShift;
			endcase
		end
	end

	// Bypass register
	always_ff @(posedge tck) begin
		if (tapReset) begin
			bypassBit <= 1'b0;
		end else if (tapState == BST_CAP_DR) begin
			bypassBit <= 1'b0;
		end else if (tapState == BST_SHIFT_DR) begin
			bypassBit <= tdi;
		end
	end

	// Pin control per instruction
	genvar g;
	generate
		for (g = 0; g < BST_NUM_IOB; g++) begin : gIob
			localparam int B = BST_IOB_BASE + BST_CELLS_PER_IOB * g;
			assign iobPadOut[g] = isExtest ? bsrHold[B + BST_CELL_OUT] : iobCoreOut[g];
			assign iobPadOe[g] = isConfig ? 1'b0 :
				(isExtest ? bsrHold[B + BST_CELL_OE] : iobCoreOe[g]);
			assign iobCoreIn[g] = padSync2[g];
		end
	endgenerate
	assign inOnlyCore = inOnlySync[1];
	assign outOnlyPad = isConfig ? 1'b0 : (isExtest ? bsrHold[BST_OUT_ONLY_BASE] : outOnlyCore);
	assign update_test_bit = bsrHold[BST_UPD_BIT];
	assign configDisable = isConfig;

	// User hooks
	assign user_instr_one_select = (instr == BST_IR_USER1);
	assign user_instr_two_select = (instr == BST_IR_USER2);
	assign run_idle_clock_nand = !(tck && tapState == BST_IDLE);

	// Enable changes on the falling edge so the exported clock has no glitch
	always_ff @(negedge tck) begin
		if (tapReset) begin
			drClockEn <= 1'b0;
		end else begin
			drClockEn <= (tapState == BST_CAP_DR || tapState == BST_SHIFT_DR);
		end
	end
	assign data_reg_shift_clock = tck && drClockEn;

	// Serial output source
	always_comb begin
		if (tapState == BST_SHIFT_IR) begin
			tdoSel = irShift[0];
		end else begin
			case (instr)
				BST_IR_EXTEST: tdoSel = bsrShift[0];
				BST_IR_SAMPLE: tdoSel = bsrShift[0];
				BST_IR_USER1: tdoSel = user_scan_out_one;
				BST_IR_USER2: tdoSel = user_scan_out_two;
				BST_IR_READBACK: tdoSel = readbackData;
				BST_IR_CONFIGURE: tdoSel = configChainOut;
				default: tdoSel = bypassBit;
			endcase
		end
	end

	// TDO changes on the falling edge and is released outside shift states
	always_ff @(negedge tck) begin
		if (tapReset) begin
			tdoOut <= 1'b0;
			tdoOe <= 1'b0;
		end else begin
			tdoOut <= tdoSel;
			tdoOe <= (tapState == BST_SHIFT_IR || tapState == BST_SHIFT_DR);
		end
	end

	// Configure: gather TDI bits into words, MSB first
	always_ff @(posedge tck) begin
		if (tapReset) begin
			cfgShift <= '0;
			cfgWord <= '0;
			cfgBitCnt <= '0;
			reqToggle <= 1'b0;
		end else if (isConfig && tapState == BST_SHIFT_DR) begin
			cfgShift <= {cfgShift[BST_CFG_WIDTH-2:0], tdi};
			cfgBitCnt <= cfgBitCnt + 1'b1;
			// A word is handed over only when the previous one has been acknowledged
			if (cfgBitCnt == '1 && reqToggle == ackSync[1]) begin
				cfgWord <= {cfgShift[BST_CFG_WIDTH-2:0], tdi};
				reqToggle <= !reqToggle;
			end
		end
	end

	always_ff @(posedge tck) begin
		ackSync <= {ackSync[0], ackToggle};
	end

	// System clock side of the word handshake
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reqSync <= '0;
			pending <= 1'b0;
			ackToggle <= 1'b0;
		end else begin
			reqSync <= {reqSync[1:0], reqToggle};
			if (pending && fifoReady) begin
				pending <= 1'b0;
				ackToggle <= !ackToggle;
			end else if (reqSync[2] != reqSync[1]) begin
				pending <= 1'b1;
			end
		end
	end

	// cfgWord is stable while a request is outstanding
	bst_fifo #(
		.WIDTH(BST_CFG_WIDTH),
		.DEPTH(BST_FIFO_DEPTH)
	) uFifo (
		.clk(ref_clk),
		.reset(reset),
		.inValid(pending),
		.inReady(fifoReady),
		.inData(cfgWord),
		.outValid(cfgValid),
		.outReady(cfgReady),
		.outData(cfgData)
	);
endmodule

/* File: bst_test_port_props.sv */
// Concurrent checks on the pins of the boundary-scan test port
`timescale 1ns/100ps
module bst_test_port_props (
	// System clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Serial test interface
	input wire logic tck,
	input wire logic tdoOe,
	// Pad drive and core side
	input wire logic [bst_pkg::BST_NUM_IOB-1:0] iobPadOut,
	input wire logic [bst_pkg::BST_NUM_IOB-1:0] iobPadOe,
	input wire logic [bst_pkg::BST_NUM_IOB-1:0] iobCoreOut,
	input wire logic [bst_pkg::BST_NUM_IOB-1:0] iobCoreOe,
	// User hooks
	input wire logic user_instr_one_select,
	input wire logic user_instr_two_select,
	input wire logic data_reg_shift_clock,
	input wire logic run_idle_clock_nand,
	input wire logic configDisable,
	// Configuration words
	input wire logic cfgValid,
	input wire logic cfgReady,
	input wire logic [bst_pkg::BST_CFG_WIDTH-1:0] cfgData
);
	import bst_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence word_waits_s;
		cfgValid && !cfgReady;
	endsequence
	sequence word_held_s;
		cfgValid && $stable(cfgData);
	endsequence
	sel_onehot_a:
	assert property ($onehot0({user_instr_one_select, user_instr_two_select, configDisable}))
		else $error("instruction decodes overlap");
	cfg_pins_off_a:
	assert property (configDisable |-> iobPadOe == '0)
		else $error("pads driven while configuring");
	idle_nand_a:
	assert property (!tck |-> run_idle_clock_nand)
		else $error("idle nand low with test clock low");
	drck_gated_a:
	assert property (!tck |-> !data_reg_shift_clock)
		else $error("data register clock high with test clock low");
	user_one_pins_a:
	assert property (user_instr_one_select |-> iobPadOut == iobCoreOut && iobPadOe == iobCoreOe)
		else $error("pads not from logic under first user instruction");
	user_two_pins_a:
	assert property (user_instr_two_select |-> iobPadOut == iobCoreOut && iobPadOe == iobCoreOe)
		else $error("pads not from logic under second user instruction");
	cfg_word_held_a:
	assert property (word_waits_s |=> word_held_s)
		else $error("config word dropped before it was taken");
	tdo_idle_off_a:
	assert property (tck && !run_idle_clock_nand |-> !tdoOe)
		else $error("serial output driven in idle");
endmodule

bind bst_test_port bst_test_port_props u_props (.ref_clk, .reset, .tck, .tdoOe, .iobPadOut,
	.iobPadOe, .iobCoreOut, .iobCoreOe, .user_instr_one_select, .user_instr_two_select,
	.data_reg_shift_clock, .run_idle_clock_nand, .configDisable, .cfgValid, .cfgReady, .cfgData);

/* File: bst_scan_ctrl.sv */
// Board-level scan controller model driving the serial test pins
`timescale 1ns/100ps
module bst_scan_ctrl (
	// Serial test interface
	output logic tck,
	output logic tms,
	output logic tdi
);
	logic phase = 1'b0;
	logic run = 1'b0;
	initial begin
		tms = 1'b1;
		tdi = 1'b0;
		#1.3;
		forever #6 phase = ~phase;
	end
	// Clock stands low between frames
	assign tck = phase & run;
	// Change pins on the falling edge, one rising edge per step
	task automatic step(input logic m, input logic d);
		@(negedge phase);
		run = 1'b1;
		tms = m;
		tdi = d;
		@(posedge phase);
	endtask
	task automatic halt();
		@(negedge phase);
		run = 1'b0;
		tdi = ~tdi;
	endtask
endmodule

/* File: bst_test_port_test.sv */
// Self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
module bst_test_port_test;
	import bst_pkg::*;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic tck, tms, tdi, tdoOut, tdoOe;
	logic scanOption = 1'b1;
	logic [BST_NUM_IOB-1:0] iobPadIn = '0, iobCoreOut = '0, iobCoreOe = '0;
	logic [BST_NUM_IOB-1:0] iobPadOut, iobPadOe, iobCoreIn;
	logic inOnlyPad = 1'b0, outOnlyCore = 1'b0, inOnlyCore, outOnlyPad;
	logic user_scan_out_one = 1'b0, user_scan_out_two = 1'b0;
	logic configChainOut = 1'b0, readbackData = 1'b0, cfgReady = 1'b0;
	logic user_instr_one_select, user_instr_two_select, data_reg_shift_clock;
	logic run_idle_clock_nand, update_test_bit, configDisable, cfgValid;
	logic [BST_CFG_WIDTH-1:0] cfgData;
	logic [1:0] tdoQ[$];
	logic [7:0] cfgQ[$];
	logic [7:0] rnd = 8'h09;
	int num_errors = 0;
	int check_count = 0;
	int shiftClockCount = 0;
	bst_test_port uut (.*);
	bst_scan_ctrl ctrl (.tck(tck), .tms(tms), .tdi(tdi));
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Exported data register clock pulses, one per capture and one per shift
	always @(posedge data_reg_shift_clock) begin
		shiftClockCount++;
	end
	// Serial output bits are compared as the controller samples them
	always @(posedge tck) begin
		logic [1:0] e;
		if (tdoOe === 1'b1) begin
			e = tdoQ.size() ? tdoQ.pop_front() : {1'b1, ~tdoOut};
			if (e[1]) check(tdoOut, e[0]);
		end
	end
	always @(posedge ref_clk) begin
		if (cfgValid === 1'b1 && cfgReady === 1'b1)
			check(cfgData, cfgQ.size() ? cfgQ.pop_front() : 8'hxx);
		rnd <= lfsr(rnd);
		cfgReady <= rnd[0] | rnd[3];
	end
	task automatic scan(input logic ir, input int n, input logic [31:0] bits,
		input logic [31:0] exp, input logic [31:0] care);
		ctrl.step(1'b1, 1'b0);
		if (ir)
			ctrl.step(1'b1, 1'b0);
		ctrl.step(1'b0, 1'b0);
		ctrl.step(1'b0, 1'b0);
		for (int i = 0; i < n; i++) begin
			tdoQ.push_back({care[i], exp[i]});
			ctrl.step(i == n - 1, bits[i]);
		end
		ctrl.step(1'b1, 1'b0);
		ctrl.step(1'b0, 1'b0);
		ctrl.halt();
	endtask
	task automatic ir(input logic [2:0] c);
		scan(1'b1, 3, {29'h0, c}, 32'h0000_0001, 32'h0000_0007);
	endtask
	function automatic logic [31:0] cap(input logic [BST_BSR_LEN-1:0] old);
		logic [31:0] e;
		e = old;
		for (int i = 0; i < BST_NUM_IOB; i++) begin
			e[BST_IOB_BASE + BST_CELLS_PER_IOB * i + BST_CELL_IN] = iobPadIn[i];
			e[BST_IOB_BASE + BST_CELLS_PER_IOB * i + BST_CELL_OUT] = iobCoreOut[i];
			e[BST_IOB_BASE + BST_CELLS_PER_IOB * i + BST_CELL_OE] = iobCoreOe[i];
		end
		e[BST_IN_ONLY_BASE] = inOnlyPad;
		e[BST_OUT_ONLY_BASE] = outOnlyCore;
		return e;
	endfunction
	task automatic pinchk(input logic [BST_BSR_LEN-1:0] p);
		for (int i = 0; i < BST_NUM_IOB; i++) begin
			check(iobPadOut[i], p[BST_IOB_BASE + BST_CELLS_PER_IOB * i + BST_CELL_OUT]);
			check(iobPadOe[i], p[BST_IOB_BASE + BST_CELLS_PER_IOB * i + BST_CELL_OE]);
		end
		check(outOnlyPad, p[BST_OUT_ONLY_BASE]);
		check(update_test_bit, p[BST_UPD_BIT]);
	endtask
	initial begin
		logic [31:0] b;
		logic [7:0] w;
		logic [BST_BSR_LEN-1:0] pre;
		fork
			begin
				repeat (12) @(posedge ref_clk);
				reset <= 1'b0;
			end
			begin
				// Test clock runs while reset is held so the test logic sees it
				repeat (3) ctrl.step(1'b1, 1'b0);
				ctrl.halt();
			end
		join
		repeat (4) @(posedge ref_clk);
		repeat (5) ctrl.step(1'b1, 1'b0);
		ctrl.step(1'b0, 1'b0);
		ctrl.halt();
		// Each source in turn is the only one high
		for (int c = 2; c < 8; c++) begin
			@(posedge ref_clk);
			{user_scan_out_one, user_scan_out_two, readbackData, configChainOut} <=
				(c < 6) ? 4'h8 >> (c - 2) : 4'h0;
			b = {16'h0000, rnd, lfsr(rnd)};
			ir(c[2:0]);
			check(user_instr_one_select, c == 2);
			check(user_instr_two_select, c == 3);
			check(configDisable, c == 5);
			if (c == 5) begin
				w = {<<{b[7:0]}};
				cfgQ.push_back(w);
				w = {<<{b[15:8]}};
				cfgQ.push_back(w);
			end
			scan(1'b0, 16, b, (c >= 6) ? {b[14:0], 1'b0} : 32'h0000_ffff, 32'h0000_ffff);
		end
		@(posedge ref_clk);
		iobPadIn <= rnd[3:0];
		iobCoreOut <= rnd[7:4];
		iobCoreOe <= ~rnd[5:2];
		inOnlyPad <= rnd[1];
		outOnlyCore <= rnd[6];
		pre = {rnd, lfsr(rnd), rnd[0]};
		repeat (4) @(posedge ref_clk);
		ir(BST_IR_SAMPLE);
		scan(1'b0, BST_BSR_LEN, pre, cap(pre), 32'h0000_fffc);
		ir(BST_IR_EXTEST);
		pinchk(pre);
		scan(1'b0, BST_BSR_LEN, ~pre, cap(pre), 32'h0001_ffff);
		pinchk(~pre);
		repeat (60) @(posedge ref_clk);
		check(tdoQ.size() + cfgQ.size(), 0);
		check(iobCoreIn, iobPadIn);
		check(inOnlyCore, inOnlyPad);
		check(shiftClockCount, 6 * 17 + 2 * (BST_BSR_LEN + 1));
		tally_and_finish();
	end
	initial begin
		#50000;
		num_errors++;
		tally_and_finish();
	end
	task automatic tally_and_finish();
		$display("Checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
endmodule
